/* File: cti_pkg.sv */
package cti_pkg;

    // Core clock
    localparam int unsigned CLK_HZ = 40_000_000;

    // Write oscillator and its divided clocks
    localparam int unsigned OSC_HZ = 9_600;
    localparam int unsigned OSC_CYCLES = CLK_HZ / OSC_HZ;

    // Read side timing, times in ns
    localparam int unsigned PULSE_NS = 1_000;
    localparam int unsigned PULSE_CYCLES = (PULSE_NS * (CLK_HZ / 1_000_000)) / 1_000;
    localparam int unsigned SAMPLE_NS = 301_000;
    localparam int unsigned SAMPLE_CYCLES = (SAMPLE_NS * (CLK_HZ / 1_000_000)) / 1_000;
    localparam int unsigned IDLE_NS = 2_000_000;
    localparam int unsigned IDLE_CYCLES = (IDLE_NS * (CLK_HZ / 1_000_000)) / 1_000;

    // Counter widths
    localparam int OSC_W = 13;
    localparam int PULSE_W = 6;
    localparam int SAMPLE_W = 15;
    localparam int IDLE_W = 17;

    // Command latch bit positions
    localparam int CMD_IRQ_EN = 0;
    localparam int CMD_MOVE = 1;
    localparam int CMD_REWIND = 2;
    localparam int CMD_WRITE = 3;
    localparam logic [3:0] CMD_RESET = 4'h0;

    // Status word bit positions
    localparam int ST_SHIFTER_ACTIVE = 0;
    localparam int ST_READY_FOR_BYTE = 1;
    localparam int ST_BYTE_AVAILABLE = 2;
    localparam int ST_END_OF_RECORD = 3;
    localparam int ST_LEADER_DETECT = 4;
    localparam int ST_WRITE_PROTECT = 5;
    localparam int ST_CASSETTE_SIDE = 6;
    localparam int ST_CASSETTE_PRESENT = 7;

    // Byte framing
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [7:0] IRQ_VECTOR = 8'h02;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // Write buffer
    localparam int BUF_DEPTH = 2;
    localparam logic [1:0] BUF_FULL = 2'h2;

endpackage : cti_pkg

/* File: cti_tape_if.sv */
// Functional notes
// - Latch interrupt enable, move, rewind and write commands from the bus until rewritten.
// - Latched commands drive tape_move_n, direction_select and record_select to the drive.
// - Status carries cassette_present, cassette_side, write_protect and leader_detect.
// - Status carries end_of_record, byte_available, ready_for_byte and shifter_active.
// - Status packed in one byte, driven on the bus only on status read.
// - Write timing from 9.6 kHz tick, divided by two twice.
// - Divided clocks form a load pulse and a shift pulse for the shifter.
// - Byte write drops ready_for_byte and captures the bus byte into holding storage.
// - Load pulse into the shifter is aligned to the write master clock.
// - After load shifter_active sets and ready_for_byte returns unless a second byte is held.
// - Each shifted bit is held in a bit latch, then phase encoded.
// - Bit counter at eight loads any held byte, keeping shifter_active set, else clears shifter_active.
// - With no further byte, shifter stays idle and shifting stops.
// - Every tape data transition yields a 1 us pulse.
// - Tape level sampled into read shift register on a 301 us timing.
// - Pulse trailing edge counts bits; at eight latch byte, set byte_available.
// - Reading the byte clears byte_available and rearms the reader.
// - Transfer indication low from first read transition until transfer completes.
// - byte_available or ready_for_byte rising asserts active low irq_n.
// - Grant while request pending drives data line 1 high and module_ack.
// - Pending interrupt cleared by controller signal and by reset.
// - Data input read withdraws the interrupt request.
// - Forward: direction low, move low; rewind: direction high, move low.
// - Command, status, data write and data read transfers, and a grant with a request pending, are answered with module_ack while data moves.
module cti_tape_if
    import cti_pkg::*;
#(
    parameter int unsigned OSC_TICK_CYCLES = cti_pkg::OSC_CYCLES,
    parameter int unsigned SAMPLE_WAIT_CYCLES = cti_pkg::SAMPLE_CYCLES,
    parameter int unsigned IDLE_WAIT_CYCLES = cti_pkg::IDLE_CYCLES
)
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic cmd_wr_i,
    input wire logic status_rd_i,
    input wire logic data_wr_i,
    input wire logic data_rd_i,
    input wire logic irq_clear_i,
    input wire logic irq_grant_i,
    input wire logic [7:0] bus_data_i,
    output logic [7:0] bus_data_o,
    output logic bus_data_oe_n_o,
    output logic module_ack_o,
    output logic irq_n_o,
    output logic write_space_o,
    input wire logic cassette_present_i,
    input wire logic cassette_side_i,
    input wire logic write_protect_i,
    input wire logic leader_detect_i,
    input wire logic tape_data_i,
    output logic tape_move_n_o,
    output logic direction_select_o,
    output logic record_select_o,
    output logic tape_write_o,
    output logic transfer_idle_o
);
    import cti_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers

    logic rst_meta;
    logic rst_n;
    logic [4:0] pin_meta;
    logic [4:0] pin_sync;

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_meta <= 5'h00;
            pin_sync <= 5'h00;
        end
        else
        begin
            pin_meta <= {tape_data_i, leader_detect_i, write_protect_i,
                         cassette_side_i, cassette_present_i};
            pin_sync <= pin_meta;
        end
    end

    logic tape_level;
    assign tape_level = pin_sync[4];

    ////////////////////////////////////////////////////////////////////////////
    // Command latch

    logic [3:0] cmd;

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
            cmd <= CMD_RESET;
        else if (cmd_wr_i)
            cmd <= bus_data_i[3:0];
    end

    assign tape_move_n_o = ~(cmd[CMD_MOVE] | cmd[CMD_REWIND]);
    assign direction_select_o = cmd[CMD_REWIND];
    assign record_select_o = cmd[CMD_WRITE];

    ////////////////////////////////////////////////////////////////////////////
    // Write timing: 9.6 kHz tick and its halves

    logic [OSC_W-1:0] osc_cnt;
    logic osc_tick;
    logic [1:0] osc_div;
    logic half_tick;
    logic cell_tick;

    assign osc_tick = (osc_cnt == OSC_W'(OSC_TICK_CYCLES - 1));

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            osc_cnt <= '0;
            osc_div <= 2'h0;
        end
        else if (osc_tick)
        begin
            osc_cnt <= '0;
            osc_div <= osc_div + 2'h1;
        end
        else
            osc_cnt <= osc_cnt + OSC_W'(1);
    end

    assign half_tick = osc_tick && (osc_div == 2'h1);
    assign cell_tick = osc_tick && (osc_div == 2'h3);

    ////////////////////////////////////////////////////////////////////////////
    // Two-entry holding buffer between bus and shifter

    logic [7:0] buf_mem [BUF_DEPTH];
    logic buf_wr_ptr;
    logic buf_rd_ptr;
    logic [1:0] buf_count;
    logic buf_push;
    logic buf_pop;
    logic buf_valid;
    logic shifter_active;
    logic [7:0] shift_reg;
    logic [2:0] wr_bits;
    logic bit_latch;
    logic second_half;

    // Second slot lets a write issued before ready_for_byte returns survive
    assign write_space_o = (buf_count != BUF_FULL);
    assign buf_valid = (buf_count != 2'h0);
    assign buf_push = data_wr_i && write_space_o;
    assign buf_pop = cell_tick && buf_valid && (!shifter_active || wr_bits == LAST_BIT);

    always_ff @(posedge clock_i)
    begin
        if (buf_push)
            buf_mem[buf_wr_ptr] <= bus_data_i;
    end

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            buf_wr_ptr <= 1'b0;
            buf_rd_ptr <= 1'b0;
            buf_count <= 2'h0;
        end
        else
        begin
            if (buf_push)
                buf_wr_ptr <= ~buf_wr_ptr;
            if (buf_pop)
                buf_rd_ptr <= ~buf_rd_ptr;
            buf_count <= buf_count + {1'b0, buf_push} - {1'b0, buf_pop};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write shifter, bit latch and phase encoder

    logic ready_for_byte;

    // not ready while a byte is held
    // ready again once the byte moves on
    assign ready_for_byte = !buf_valid;

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shifter_active <= 1'b0;
            shift_reg <= BYTE_RESET;
            wr_bits <= 3'h0;
            bit_latch <= 1'b0;
        end
        else if (cell_tick)
        begin
            if (buf_pop)
            begin
                shifter_active <= 1'b1;
                shift_reg <= {1'b0, buf_mem[buf_rd_ptr][7:1]};
                wr_bits <= 3'h0;
                bit_latch <= buf_mem[buf_rd_ptr][0];
            end
            else if (shifter_active && wr_bits == LAST_BIT)
            begin
                shifter_active <= 1'b0;
                wr_bits <= 3'h0;
            end
            else if (shifter_active)
            begin
                bit_latch <= shift_reg[0];
                shift_reg <= {1'b0, shift_reg[7:1]};
                wr_bits <= wr_bits + 3'h1;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
            second_half <= 1'b0;
        else if (cell_tick)
            second_half <= 1'b0;
        else if (half_tick)
            second_half <= 1'b1;
    end

    // mid-cell edge carries the bit; line rests low when idle
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
            tape_write_o <= 1'b0;
        else if (!shifter_active)
            tape_write_o <= 1'b0;
        else
            tape_write_o <= second_half ? bit_latch : ~bit_latch;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read: transition pulse, blanking, bit assembly

    logic tape_last;
    logic edge_seen;
    logic [PULSE_W-1:0] pulse_cnt;
    logic pulse_end;
    logic [SAMPLE_W-1:0] blank_cnt;
    logic [IDLE_W-1:0] idle_cnt;
    logic reading;
    logic [7:0] rd_shift;
    logic [2:0] rd_bits;
    logic [7:0] rd_byte;
    logic byte_available;
    logic end_of_record;
    logic byte_done;

    assign edge_seen = (tape_level != tape_last);

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tape_last <= 1'b0;
            pulse_cnt <= '0;
        end
        else
        begin
            tape_last <= tape_level;
            if (edge_seen)
                pulse_cnt <= PULSE_W'(PULSE_CYCLES);
            else if (pulse_cnt != '0)
                pulse_cnt <= pulse_cnt - PULSE_W'(1);
        end
    end

    // Trailing edge of the pulse, outside the blanking window
    assign pulse_end = (pulse_cnt == PULSE_W'(1)) && !edge_seen && (blank_cnt == '0);
    assign byte_done = pulse_end && (rd_bits == LAST_BIT);

    // cell-boundary edges fall inside the 301 us window and are skipped
    // level after the accepted edge is the bit
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            blank_cnt <= '0;
            rd_shift <= BYTE_RESET;
            rd_bits <= 3'h0;
            rd_byte <= BYTE_RESET;
        end
        else
        begin
            if (pulse_end)
            begin
                blank_cnt <= SAMPLE_W'(SAMPLE_WAIT_CYCLES);
                rd_shift <= {tape_level, rd_shift[7:1]};
                rd_bits <= rd_bits + 3'h1;
            end
            else if (blank_cnt != '0)
                blank_cnt <= blank_cnt - SAMPLE_W'(1);
            if (byte_done)
                rd_byte <= {tape_level, rd_shift[7:1]};
            if (!reading)
                rd_bits <= 3'h0;
        end
    end

    // cleared when the byte is read; the set wins
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
            byte_available <= 1'b0;
        else if (byte_done)
            byte_available <= 1'b1;
        else if (data_rd_i)
            byte_available <= 1'b0;
    end

    // transfer active from first edge until the line falls quiet
    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reading <= 1'b0;
            idle_cnt <= '0;
            end_of_record <= 1'b0;
        end
        else
        begin
            if (edge_seen && !cmd[CMD_WRITE])
            begin
                reading <= 1'b1;
                idle_cnt <= IDLE_W'(IDLE_WAIT_CYCLES);
            end
            else if (idle_cnt != '0)
                idle_cnt <= idle_cnt - IDLE_W'(1);
            else
                reading <= 1'b0;
            if (reading && idle_cnt == IDLE_W'(1) && !edge_seen)
                end_of_record <= 1'b1;
            else if (cmd_wr_i)
                end_of_record <= 1'b0;
        end
    end

    assign transfer_idle_o = !reading;

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt request

    logic ready_last;
    logic avail_last;
    logic irq_pend;
    logic irq_event;

    assign irq_event = cmd[CMD_IRQ_EN] &&
                       ((byte_available && !avail_last) || (ready_for_byte && !ready_last));

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // Matches ready_for_byte after reset, so no false rising edge
            ready_last <= 1'b1;
            avail_last <= 1'b0;
            irq_pend <= 1'b0;
        end
        else
        begin
            ready_last <= ready_for_byte;
            avail_last <= byte_available;
            if (irq_event)
                irq_pend <= 1'b1;
            else if (irq_clear_i || data_rd_i)
                irq_pend <= 1'b0;
        end
    end

    assign irq_n_o = !irq_pend;

    ////////////////////////////////////////////////////////////////////////////
    // Bus answer: registered data and acknowledge

    logic [7:0] status_word;

    always_comb
    begin
        status_word = BYTE_RESET;
        status_word[ST_CASSETTE_PRESENT] = pin_sync[0];
        status_word[ST_CASSETTE_SIDE] = pin_sync[1];
        status_word[ST_WRITE_PROTECT] = pin_sync[2];
        status_word[ST_LEADER_DETECT] = pin_sync[3];
        status_word[ST_END_OF_RECORD] = end_of_record;
        status_word[ST_BYTE_AVAILABLE] = byte_available;
        status_word[ST_READY_FOR_BYTE] = ready_for_byte;
        status_word[ST_SHIFTER_ACTIVE] = shifter_active;
    end

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_data_o <= BYTE_RESET;
            bus_data_oe_n_o <= 1'b1;
            module_ack_o <= 1'b0;
        end
        else
        begin
            module_ack_o <= cmd_wr_i || status_rd_i || data_wr_i || data_rd_i ||
                            (irq_grant_i && irq_pend);
            bus_data_oe_n_o <= !(status_rd_i || data_rd_i || (irq_grant_i && irq_pend));
            if (irq_grant_i && irq_pend)
                bus_data_o <= IRQ_VECTOR;
            else if (status_rd_i)
                bus_data_o <= status_word;
            else if (data_rd_i)
                bus_data_o <= rd_byte;
            else
                bus_data_o <= BYTE_RESET;
        end
    end

endmodule : cti_tape_if

/* File: cti_tape_if_monitor.sv */
module cti_tape_if_monitor
    import cti_pkg::*;
#(
    parameter int unsigned OSC_TICK_CYCLES = cti_pkg::OSC_CYCLES,
    parameter int unsigned SAMPLE_WAIT_CYCLES = cti_pkg::SAMPLE_CYCLES,
    parameter int unsigned IDLE_WAIT_CYCLES = cti_pkg::IDLE_CYCLES
)
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic cmd_wr_i,
    input wire logic status_rd_i,
    input wire logic data_wr_i,
    input wire logic data_rd_i,
    input wire logic irq_clear_i,
    input wire logic irq_grant_i,
    input wire logic [7:0] bus_data_i,
    input wire logic [7:0] bus_data_o,
    input wire logic bus_data_oe_n_o,
    input wire logic module_ack_o,
    input wire logic irq_n_o,
    input wire logic write_space_o,
    input wire logic cassette_present_i,
    input wire logic cassette_side_i,
    input wire logic write_protect_i,
    input wire logic leader_detect_i,
    input wire logic tape_move_n_o,
    input wire logic direction_select_o,
    input wire logic record_select_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    ////////////////////////////////////////////////////////////////////////////////
    // Buffer full, so no single load can bring ready back in two cycles
    sequence s_full_write_status;
        (data_wr_i && !write_space_o) ##[1:2] status_rd_i;
    endsequence
    sequence s_valid_grant;
        irq_grant_i && !irq_n_o;
    endsequence

    ////////////////////////////////////////////////////////////////////////////////
    a_ack_follows: assert property ((cmd_wr_i || status_rd_i || data_wr_i || data_rd_i)
        |=> module_ack_o) else $error("strobe not acknowledged");
    a_ack_has_cause: assert property (module_ack_o |->
        $past(cmd_wr_i || status_rd_i || data_wr_i || data_rd_i || irq_grant_i || irq_clear_i))
        else $error("acknowledge without strobe");
    a_bus_quiet: assert property (!(status_rd_i || data_rd_i || irq_grant_i)
        |=> bus_data_oe_n_o && bus_data_o == 8'h00) else $error("bus driven unasked");
    a_status_cond: assert property (status_rd_i |=> !bus_data_oe_n_o &&
        bus_data_o[7:4] == {cassette_present_i, cassette_side_i, write_protect_i,
        leader_detect_i}) else $error("cassette status wrong");
    a_ready_drop: assert property (s_full_write_status |=>
        !bus_data_o[ST_READY_FOR_BYTE]) else $error("ready shown while buffer full");
    a_grant_vector: assert property (s_valid_grant |=> module_ack_o &&
        !bus_data_oe_n_o && bus_data_o == IRQ_VECTOR) else $error("grant answer wrong");
    a_grant_idle: assert property ((irq_grant_i && irq_n_o && !cmd_wr_i && !status_rd_i
        && !data_wr_i && !data_rd_i && !irq_clear_i) |=> !module_ack_o)
        else $error("grant answered without request");
    a_fwd_decode: assert property ((cmd_wr_i && bus_data_i[2:1] == 2'h1)
        |=> !tape_move_n_o && !direction_select_o) else $error("forward lines wrong");
    a_rwd_decode: assert property ((cmd_wr_i && bus_data_i[2:1] == 2'h2)
        |=> !tape_move_n_o && direction_select_o) else $error("rewind lines wrong");
    a_record_follow: assert property (cmd_wr_i |=>
        record_select_o == $past(bus_data_i[CMD_WRITE])) else $error("record line wrong");
    a_cmd_hold: assert property (!cmd_wr_i |=>
        $stable({tape_move_n_o, direction_select_o, record_select_o}))
        else $error("command lines moved without command");
    a_irq_clear: assert property (irq_clear_i |-> ##[1:2] irq_n_o)
        else $error("interrupt not cleared");
    a_read_withdraw: assert property (data_rd_i |-> ##[1:2] irq_n_o)
        else $error("interrupt kept after data read");
endmodule : cti_tape_if_monitor

bind cti_tape_if cti_tape_if_monitor #(
    .OSC_TICK_CYCLES(OSC_TICK_CYCLES),
    .SAMPLE_WAIT_CYCLES(SAMPLE_WAIT_CYCLES),
    .IDLE_WAIT_CYCLES(IDLE_WAIT_CYCLES)
) u_mon (.clock_i(clock_i), .rst_n_i(rst_n_i), .cmd_wr_i(cmd_wr_i),
    .status_rd_i(status_rd_i), .data_wr_i(data_wr_i), .data_rd_i(data_rd_i),
    .irq_clear_i(irq_clear_i), .irq_grant_i(irq_grant_i), .bus_data_i(bus_data_i),
    .bus_data_o(bus_data_o), .bus_data_oe_n_o(bus_data_oe_n_o),
    .module_ack_o(module_ack_o), .irq_n_o(irq_n_o), .write_space_o(write_space_o),
    .cassette_present_i(cassette_present_i), .cassette_side_i(cassette_side_i),
    .write_protect_i(write_protect_i), .leader_detect_i(leader_detect_i),
    .tape_move_n_o(tape_move_n_o), .direction_select_o(direction_select_o),
    .record_select_o(record_select_o));

/* File: cti_tape_model.sv */
module cti_tape_model (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [3:0] cond_i,
    input wire logic tape_move_n_i,
    input wire logic direction_select_i,
    input wire logic record_select_i,
    input wire logic tape_write_i,
    output logic [3:0] cond_o,
    output logic tape_data_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // Two-state track: unrecorded tape reads as a steady low, never unknown
    bit track [0:16383];
    logic [13:0] pos;

    assign cond_o = cond_i;

    ////////////////////////////////////////////////////////////////////////////////
    // tape_move_n and direction
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pos <= 14'h0000;
            tape_data_o <= 1'h0;
        end
        else if (!tape_move_n_i && direction_select_i)
            pos <= 14'h0000;
        else if (!tape_move_n_i)
        begin
            pos <= pos + 14'h0001;
            if (record_select_i)
                track[pos] <= tape_write_i;
            else
                tape_data_o <= track[pos];
        end
    end
endmodule : cti_tape_model

/* File: tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import cti_pkg::*;
    logic clock_i = 1'h0;
    logic rst_n_i = 1'h0;
    logic [5:0] stb = 6'h00;
    logic [7:0] bus_data_i = 8'h00;
    logic [3:0] cond;
    logic [3:0] pins;
    logic tape_data;
    logic [7:0] bus_data_o;
    logic bus_data_oe_n_o, module_ack_o, irq_n_o, write_space_o;
    logic tape_move_n_o, direction_select_o, record_select_o, tape_write_o, transfer_idle_o;
    logic [8:0] notes [$];
    logic [8:0] note;
    logic [7:0] b [4];
    logic [7:0] cmds [4] = '{8'h00, 8'h02, 8'h04, 8'h09};
    logic [2:0] outs [4] = '{3'h4, 3'h0, 3'h2, 3'h5};
    int seed = 15619;
    int err_total = 0;
    int compares = 0;
    int edges;
    logic last;

    always #12.5 clock_i = ~clock_i;

    // Shortened oscillator: cell of 160 clocks, blanking spans the cell boundary edge
    cti_tape_if #(.OSC_TICK_CYCLES(40), .SAMPLE_WAIT_CYCLES(90), .IDLE_WAIT_CYCLES(200)) uut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .cmd_wr_i(stb[0]), .status_rd_i(stb[1]),
        .data_wr_i(stb[2]), .data_rd_i(stb[3]), .irq_clear_i(stb[4]), .irq_grant_i(stb[5]),
        .bus_data_i(bus_data_i), .bus_data_o(bus_data_o), .bus_data_oe_n_o(bus_data_oe_n_o),
        .module_ack_o(module_ack_o), .irq_n_o(irq_n_o), .write_space_o(write_space_o),
        .cassette_present_i(pins[3]), .cassette_side_i(pins[2]), .write_protect_i(pins[1]),
        .leader_detect_i(pins[0]), .tape_data_i(tape_data), .tape_move_n_o(tape_move_n_o),
        .direction_select_o(direction_select_o), .record_select_o(record_select_o),
        .tape_write_o(tape_write_o), .transfer_idle_o(transfer_idle_o));

    cti_tape_model u_tape (.clock_i(clock_i), .rst_n_i(rst_n_i), .cond_i(cond),
        .tape_move_n_i(tape_move_n_o), .direction_select_i(direction_select_o),
        .record_select_i(record_select_o), .tape_write_i(tape_write_o), .cond_o(pins),
        .tape_data_o(tape_data));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic report_and_stop();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    // One strobe cycle; the expected answer is noted for the watcher
    task automatic bus(input int which, input logic [7:0] d, input bit noted,
        input logic [8:0] exp);
        @(negedge clock_i);
        stb[which] = 1'h1;
        bus_data_i = d;
        if (noted)
            notes.push_back(exp);
        @(negedge clock_i);
        stb[which] = 1'h0;
    endtask : bus

    task automatic wait_for(input int sel, input int limit);
        int n;
        n = 0;
        while ((sel == 0 ? irq_n_o !== 1'h0 : transfer_idle_o !== 1'h1) && n < limit)
        begin
            @(negedge clock_i);
            n++;
        end
        if (n >= limit)
        begin
            err_total++;
            report_and_stop();
        end
    endtask : wait_for

    function automatic logic [8:0] st(input logic [3:0] f);
        return {1'h0, cond, f};
    endfunction : st

    ////////////////////////////////////////////////////////////////////////////////
    always @(negedge clock_i)
    begin
        if (module_ack_o === 1'h1 && notes.size() > 0)
        begin
            note = notes.pop_front();
            check("bus answer", {bus_data_oe_n_o, bus_data_o}, note);
        end
    end

    initial
    begin
        cond = 4'($random(seed));
        for (int i = 0; i < 4; i++)
            b[i] = 8'($random(seed));
        // First cell must hold no boundary edge out of the idle low level
        b[0][0] = 1'h1;
        repeat (20) @(negedge clock_i);
        rst_n_i = 1'h1;
        repeat (3) @(negedge clock_i);
        check("reset outputs", {2'h0, irq_n_o, tape_move_n_o, direction_select_o,
            record_select_o, tape_write_o, transfer_idle_o, write_space_o}, 9'h063);
        bus(1, 8'h00, 1, st(4'h2));
        bus(5, 8'h00, 0, 9'h000);
        check("idle grant", {8'h00, module_ack_o}, 9'h000);
        for (int i = 0; i < 4; i++)
        begin
            bus(0, cmds[i], 1, 9'h100);
            @(negedge clock_i);
            check("drive lines", {6'h00, tape_move_n_o, direction_select_o, record_select_o},
                {6'h00, outs[i]});
        end
        bus(0, 8'h0B, 1, 9'h100);
        bus(2, b[0], 1, 9'h100);
        wait_for(0, 400);
        check("ready irq", {8'h00, irq_n_o}, 9'h000);
        bus(5, 8'h00, 1, {1'h0, IRQ_VECTOR});
        bus(4, 8'h00, 0, 9'h000);
        bus(2, b[1], 1, 9'h100);
        check("irq cleared", {8'h00, irq_n_o}, 9'h001);
        bus(2, b[2], 1, 9'h100);
        check("buffer space", {8'h00, write_space_o}, 9'h000);
        bus(2, b[3], 1, 9'h100);
        bus(1, 8'h00, 1, st(4'h1));
        wait_for(0, 3000);
        bus(4, 8'h00, 0, 9'h000);
        repeat (1400) @(negedge clock_i);
        bus(1, 8'h00, 1, st(4'h2));
        edges = 0;
        last = tape_write_o;
        repeat (320)
        begin
            @(negedge clock_i);
            edges += (tape_write_o !== last) ? 1 : 0;
            last = tape_write_o;
        end
        check("write line still", 9'(edges), 9'h000);
        bus(0, 8'h05, 1, 9'h100);
        repeat (20) @(negedge clock_i);
        bus(0, 8'h03, 1, 9'h100);
        for (int i = 0; i < 3; i++)
        begin
            wait_for(0, 2000);
            check("reading", {8'h00, transfer_idle_o}, 9'h000);
            bus(1, 8'h00, 1, st(4'h6));
            bus(3, 8'h00, 1, {1'h0, b[i]});
            @(negedge clock_i);
            check("irq withdrawn", {8'h00, irq_n_o}, 9'h001);
        end
        wait_for(1, 1000);
        bus(1, 8'h00, 1, st(4'hA));
        bus(0, 8'h00, 1, 9'h100);
        bus(1, 8'h00, 1, st(4'h2));
        repeat (3) @(negedge clock_i);
        check("notes left", 9'(notes.size()), 9'h000);
        report_and_stop();
    end
endmodule : tb
